// >>> src/gfx_cfg_pkg.sv
// Constants and carrier types for the graphics mode configuration registers
package gfx_cfg_pkg;

  // Configuration functions
  localparam logic [2:0]  FUNC_HOST           = 3'h0;
  localparam logic [2:0]  FUNC_BRIDGE         = 3'h1;

  // Byte offsets, function 0; the port registers are absent and read as zero
  localparam logic [7:0]  OFF_APERTURE_BASE   = 8'h10;
  localparam logic [7:0]  OFF_PORT_MISC       = 8'h51;
  localparam logic [7:0]  OFF_GRAPHICS_CTRL   = 8'h52;
  localparam logic [7:0]  OFF_PORT_CAP_IDENT  = 8'hA0;
  localparam logic [7:0]  OFF_PORT_STATUS     = 8'hA4;
  localparam logic [7:0]  OFF_PORT_COMMAND    = 8'hA8;
  localparam logic [7:0]  OFF_PORT_CONTROL    = 8'hB0;
  localparam logic [7:0]  OFF_APERTURE_SIZE   = 8'hB4;
  localparam logic [7:0]  OFF_TRANSLATION_TBL = 8'hB8;
  localparam logic [7:0]  OFF_MULTI_TIMER     = 8'hBC;
  localparam logic [7:0]  OFF_LOW_PRIO_TIMER  = 8'hBD;
  localparam logic [7:0]  OFF_HUB_CFG         = 8'hC6;
  localparam logic [7:0]  OFF_ERROR_FLAGS     = 8'hC8;
  localparam logic [7:0]  OFF_ERROR_CTRL      = 8'hCA;
  localparam logic [7:0]  OFF_CAP_IDENT       = 8'hE4;
  localparam logic [7:0]  OFF_CAP_IDENT_HI    = 8'hE8;

  // Field positions
  localparam int          GFX_DISABLE_BIT     = 3;
  localparam int          HUB_MODE_BIT        = 3;
  localparam int          CAP_NEXT_PTR_LSB    = 8;

  // Reset and fixed values
  localparam logic [7:0]  GFX_CTRL_RESET      = 8'h00;
  localparam logic [7:0]  GFX_CTRL_WRITE_MASK = 8'hF7;
  localparam logic [15:0] HUB_CFG_RESET       = 16'h0000;
  localparam logic [15:0] HUB_CFG_WRITE_MASK  = 16'hFFF7;
  localparam logic [15:0] ERR_FLAGS_RESET     = 16'h0000;
  localparam logic [15:0] ERR_CTRL_RESET      = 16'h0000;
  localparam logic [15:0] ERR_LIVE_MASK       = 16'hFFE0;
  localparam logic [39:0] CAP_IDENT_VALUE     = 40'h000001060009;
  localparam logic [7:0]  CAP_NEXT_PTR_END    = 8'h00;
  localparam logic        STRAP_RESET         = 1'b0;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  func;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        done;
    logic        claimed;
    logic        forward;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic want_sync;
    logic want_independent;
    logic tv0;
    logic tv1;
    logic digital0;
    logic digital1;
  } disp_req_t;

  typedef struct packed {
    logic sync_grant;
    logic refused;
  } disp_rsp_t;

endpackage

// >>> src/strap_sampler.sv
// Display-card-detect strap capture, follows the strap during hub reset
`timescale 1ns/1ns
module strap_sampler (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic hub_reset_input_n,
  input  wire logic strap,
  output logic      sampled
);

  // Flow through while held in reset, frozen from the release on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sampled <= gfx_cfg_pkg::STRAP_RESET;
    end else if (!hub_reset_input_n) begin
      sampled <= strap;
    end
  end

  a_strap_follow: assert property (@(posedge core_clk) disable iff (rst)
    !hub_reset_input_n |=> sampled == $past(strap))
    else $error("strap not followed during hub reset");

  a_strap_hold: assert property (@(posedge core_clk) disable iff (rst)
    hub_reset_input_n && $past(hub_reset_input_n) |-> $stable(sampled))
    else $error("strap value changed after hub reset release");

endmodule

// >>> src/graphics_mode_config_regs.sv
// Function 0 configuration registers and display pipe limits, no port bridge
//
// What this block does
// - Port bridge registers of function 0 are absent; their offsets are reserved.
// - Graphics control bit 3 is read-only zero; register resets to zero.
// - Hub configuration bit 3 mirrors the sampled display-card-detect strap.
// - With mode bit 0, function 1 cycles pass through to hub.
// - Capability next pointer reads 00h, ending the capability list.
// - Capability identification is read-only, 40 bits, fixed value every read.
// - Function 1 bridge is absent; with mode bit 1 all its locations behave as reserved.
// - Dual synchronous display only when neither display is a television.
// - Never synchronous output on two digital displays together.
// - Never independent content or timing on several displays.
// - Strap follows during hub reset and is held after release.
`timescale 1ns/1ns
module graphics_mode_config_regs (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   hub_reset_input_n,
  input  wire logic                   display_card_detect,
  input  wire logic [15:0]            error_events,
  input  wire gfx_cfg_pkg::cfg_req_t  cfg_req,
  input  wire gfx_cfg_pkg::disp_req_t disp_req,
  output gfx_cfg_pkg::cfg_rsp_t       cfg_rsp,
  output gfx_cfg_pkg::disp_rsp_t      disp_rsp,
  output logic                        hub_configuration_mode_bit
);

  function automatic logic [5:0] dw(input logic [7:0] off);
    dw = off[7:2];
  endfunction

  function automatic logic [7:0] lane_byte(input logic [31:0] d, input logic [1:0] lane);
    lane_byte = d[{lane, 3'b000} +: 8];
  endfunction

  function automatic logic is_port_reg(input logic [5:0] idx);
    is_port_reg = idx == dw(gfx_cfg_pkg::OFF_APERTURE_BASE)
               || idx == dw(gfx_cfg_pkg::OFF_PORT_CAP_IDENT)
               || idx == dw(gfx_cfg_pkg::OFF_PORT_STATUS)
               || idx == dw(gfx_cfg_pkg::OFF_PORT_COMMAND)
               || idx == dw(gfx_cfg_pkg::OFF_PORT_CONTROL)
               || idx == dw(gfx_cfg_pkg::OFF_APERTURE_SIZE)
               || idx == dw(gfx_cfg_pkg::OFF_TRANSLATION_TBL)
               || idx == dw(gfx_cfg_pkg::OFF_MULTI_TIMER)
               || idx == dw(gfx_cfg_pkg::OFF_LOW_PRIO_TIMER);
  endfunction

  logic [7:0]  graphics_control;
  logic [15:0] hub_cfg_store;
  logic [15:0] error_flags;
  logic [15:0] error_reporting_control;

  strap_sampler u_strap (
    .core_clk          (core_clk),
    .rst               (rst),
    .hub_reset_input_n (hub_reset_input_n),
    .strap             (display_card_detect),
    .sampled           (hub_configuration_mode_bit)
  );

  // Request decode
  wire        req_f0   = cfg_req.valid && cfg_req.func == gfx_cfg_pkg::FUNC_HOST;
  wire        req_f1   = cfg_req.valid && cfg_req.func == gfx_cfg_pkg::FUNC_BRIDGE;
  wire        wr_f0    = req_f0 && cfg_req.write;
  wire [5:0]  idx      = cfg_req.addr[7:2];
  wire        hit_gfx  = idx == dw(gfx_cfg_pkg::OFF_GRAPHICS_CTRL);
  wire        hit_hub  = idx == dw(gfx_cfg_pkg::OFF_HUB_CFG);
  wire        hit_err  = idx == dw(gfx_cfg_pkg::OFF_ERROR_FLAGS);
  wire        hit_cap  = idx == dw(gfx_cfg_pkg::OFF_CAP_IDENT);
  wire        hit_caph = idx == dw(gfx_cfg_pkg::OFF_CAP_IDENT_HI);
  wire        hit_port = is_port_reg(idx);

  // Byte lanes of each live register within its dword
  wire [1:0]  ln_gfx   = gfx_cfg_pkg::OFF_GRAPHICS_CTRL[1:0];
  wire [1:0]  ln_hub   = gfx_cfg_pkg::OFF_HUB_CFG[1:0];
  wire [1:0]  ln_ef    = gfx_cfg_pkg::OFF_ERROR_FLAGS[1:0];
  wire [1:0]  ln_ec    = gfx_cfg_pkg::OFF_ERROR_CTRL[1:0];

  wire        wr_gfx   = wr_f0 && hit_gfx && cfg_req.be[ln_gfx];
  wire [1:0]  wr_hub   = {2{wr_f0 && hit_hub}} & {cfg_req.be[ln_hub + 2'd1], cfg_req.be[ln_hub]};
  wire [1:0]  wr_ef    = {2{wr_f0 && hit_err}} & {cfg_req.be[ln_ef + 2'd1], cfg_req.be[ln_ef]};
  wire [1:0]  wr_ec    = {2{wr_f0 && hit_err}} & {cfg_req.be[ln_ec + 2'd1], cfg_req.be[ln_ec]};

  wire [15:0] wd_hub   = {lane_byte(cfg_req.wdata, ln_hub + 2'd1), lane_byte(cfg_req.wdata, ln_hub)};
  wire [15:0] wd_ef    = {lane_byte(cfg_req.wdata, ln_ef + 2'd1), lane_byte(cfg_req.wdata, ln_ef)};
  wire [15:0] wd_ec    = {lane_byte(cfg_req.wdata, ln_ec + 2'd1), lane_byte(cfg_req.wdata, ln_ec)};
  wire [15:0] m_hub    = {{8{wr_hub[1]}}, {8{wr_hub[0]}}};
  wire [15:0] m_ef     = {{8{wr_ef[1]}}, {8{wr_ef[0]}}};
  wire [15:0] m_ec     = {{8{wr_ec[1]}}, {8{wr_ec[0]}}};

  // Bit 3 never stored, so it cannot be set by a write
  wire [7:0]  next_graphics_control = wr_gfx
    ? lane_byte(cfg_req.wdata, ln_gfx) & gfx_cfg_pkg::GFX_CTRL_WRITE_MASK
    : graphics_control;
  wire [15:0] hub_w_mask = m_hub & gfx_cfg_pkg::HUB_CFG_WRITE_MASK;
  wire [15:0] next_hub_cfg_store = (hub_cfg_store & ~hub_w_mask) | (wd_hub & hub_w_mask);
  // Write-one-to-clear; a new event in the same cycle wins over the clear
  wire [15:0] err_clear = wd_ef & m_ef & gfx_cfg_pkg::ERR_LIVE_MASK;
  wire [15:0] next_error_flags =
    (error_flags & ~err_clear) | (error_events & gfx_cfg_pkg::ERR_LIVE_MASK);
  wire [15:0] ec_w_mask = m_ec & gfx_cfg_pkg::ERR_LIVE_MASK;
  wire [15:0] next_error_reporting_control =
    (error_reporting_control & ~ec_w_mask) | (wd_ec & ec_w_mask);

  // Read view: mode bit comes from the strap, not from storage
  wire [15:0] hub_cfg_view = {hub_cfg_store[15:gfx_cfg_pkg::HUB_MODE_BIT + 1],
                              hub_configuration_mode_bit,
                              hub_cfg_store[gfx_cfg_pkg::HUB_MODE_BIT - 1:0]};
  wire [39:0] cap_view = {gfx_cfg_pkg::CAP_IDENT_VALUE[39:16],
                          gfx_cfg_pkg::CAP_NEXT_PTR_END,
                          gfx_cfg_pkg::CAP_IDENT_VALUE[7:0]};

  // Everything not listed, the port registers included, reads zero
  wire [31:0] rd_f0 =
      hit_gfx  ? {8'h00, graphics_control, 16'h0000}
    : hit_hub  ? {hub_cfg_view, 16'h0000}
    : hit_err  ? {error_reporting_control, error_flags}
    : hit_cap  ? cap_view[31:0]
    : hit_caph ? {24'h000000, cap_view[39:32]}
    : 32'h00000000;

  // Function 1 never exists; it is either forwarded or answered as reserved
  wire        fwd_f1   = req_f1 && !hub_configuration_mode_bit;
  wire        claim    = req_f0 || (req_f1 && hub_configuration_mode_bit);
  wire [31:0] next_rdata = (req_f0 && !cfg_req.write) ? rd_f0 : 32'h00000000;

  // Single pipe: mirrored output only, never with a television or two digitals
  wire        sync_ok  = disp_req.want_sync && !disp_req.tv0 && !disp_req.tv1
                      && !(disp_req.digital0 && disp_req.digital1);
  wire        disp_bad = (disp_req.want_sync && !sync_ok) || disp_req.want_independent;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      graphics_control        <= gfx_cfg_pkg::GFX_CTRL_RESET;
      hub_cfg_store           <= gfx_cfg_pkg::HUB_CFG_RESET;
      error_flags             <= gfx_cfg_pkg::ERR_FLAGS_RESET;
      error_reporting_control <= gfx_cfg_pkg::ERR_CTRL_RESET;
    end else begin
      graphics_control        <= next_graphics_control;
      hub_cfg_store           <= next_hub_cfg_store;
      error_flags             <= next_error_flags;
      error_reporting_control <= next_error_reporting_control;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_rsp  <= '0;
      disp_rsp <= '0;
    end else begin
      cfg_rsp.done       <= cfg_req.valid;
      cfg_rsp.claimed    <= claim;
      cfg_rsp.forward    <= fwd_f1;
      cfg_rsp.rdata      <= next_rdata;
      disp_rsp.sync_grant <= sync_ok;
      disp_rsp.refused    <= disp_bad;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  wire rd_f0_now = req_f0 && !cfg_req.write;

  sequence s_f1_video;
    req_f1 && !hub_configuration_mode_bit;
  endsequence

  sequence s_passed_on;
    cfg_rsp.done && cfg_rsp.forward && !cfg_rsp.claimed;
  endsequence

  a_port_regs_gone: assert property (
    rd_f0_now && hit_port |=> cfg_rsp.rdata == 32'h00000000)
    else $error("reserved port register read not zero");

  a_igd_bit_zero: assert property (
    rd_f0_now && hit_gfx |=> cfg_rsp.rdata[16 + gfx_cfg_pkg::GFX_DISABLE_BIT] == 1'b0)
    else $error("graphics disable bit reads one");

  a_mode_mirror: assert property (
    rd_f0_now && hit_hub
    |=> cfg_rsp.rdata[16 + gfx_cfg_pkg::HUB_MODE_BIT] == $past(hub_configuration_mode_bit))
    else $error("hub mode bit does not mirror strap");

  a_f1_forward: assert property (s_f1_video |=> s_passed_on)
    else $error("function 1 cycle not forwarded in video output mode");

  a_cap_list_end: assert property (
    rd_f0_now && hit_cap |=> cfg_rsp.rdata[gfx_cfg_pkg::CAP_NEXT_PTR_LSB +: 8] == 8'h00)
    else $error("capability next pointer not zero");

  a_cap_fixed: assert property (
    rd_f0_now && hit_caph |=> cfg_rsp.rdata == {24'h000000, gfx_cfg_pkg::CAP_IDENT_VALUE[39:32]})
    else $error("capability upper byte wrong");

  a_bridge_absent: assert property (
    req_f1 |=> cfg_rsp.rdata == 32'h00000000 && cfg_rsp.claimed == $past(hub_configuration_mode_bit))
    else $error("function 1 answered with data");

  a_sync_no_tv: assert property (
    disp_req.tv0 || disp_req.tv1 |=> !disp_rsp.sync_grant)
    else $error("synchronous display granted with a television");

  a_sync_two_dig: assert property (
    disp_req.digital0 && disp_req.digital1 |=> !disp_rsp.sync_grant)
    else $error("synchronous display granted on two digital ports");

  a_no_independent: assert property (
    disp_req.want_independent |=> disp_rsp.refused)
    else $error("independent display request not refused");

  a_rsvd_write_drop: assert property (
    wr_f0 && !hit_gfx && !hit_hub && !hit_err ##1 !wr_f0
    |-> $stable(graphics_control) && $stable(hub_cfg_store) && $stable(error_reporting_control))
    else $error("reserved write changed a register");

  a_err_set_wins: assert property (
    (error_events & gfx_cfg_pkg::ERR_LIVE_MASK) != 16'h0000
    |=> (error_flags & $past(error_events & gfx_cfg_pkg::ERR_LIVE_MASK))
        == $past(error_events & gfx_cfg_pkg::ERR_LIVE_MASK))
    else $error("error event lost");

  // Internal graphics mode answers function 1 locally, as reserved
  sequence s_f1_local;
    req_f1 && hub_configuration_mode_bit;
  endsequence

  a_f0_claimed: assert property (
    req_f0 |=> cfg_rsp.done && cfg_rsp.claimed && !cfg_rsp.forward)
    else $error("function 0 cycle not claimed");

  a_f1_kept_local: assert property (
    s_f1_local |=> cfg_rsp.done && cfg_rsp.claimed && !cfg_rsp.forward)
    else $error("function 1 cycle forwarded in internal graphics mode");

  a_f1_write_dropped: assert property (
    req_f1 ##1 !wr_f0
    |-> $stable(graphics_control) && $stable(hub_cfg_store) && $stable(error_reporting_control))
    else $error("function 1 write changed a register");

  a_other_func_idle: assert property (
    cfg_req.valid && cfg_req.func > gfx_cfg_pkg::FUNC_BRIDGE
    |=> cfg_rsp.done && !cfg_rsp.claimed && !cfg_rsp.forward && cfg_rsp.rdata == 32'h00000000)
    else $error("foreign function cycle answered");

  // Only a cycle to function 1 may ever be passed on
  a_no_stray_forward: assert property (
    !req_f1 |=> !cfg_rsp.forward)
    else $error("cycle forwarded without a function 1 request");

  // Register writes land through their masks only
  a_gfx_bit_ro: assert property (
    wr_gfx |=> graphics_control[gfx_cfg_pkg::GFX_DISABLE_BIT] == 1'b0)
    else $error("graphics disable bit stored by a write");

  a_gfx_write_lands: assert property (
    wr_gfx |=> graphics_control
               == ($past(lane_byte(cfg_req.wdata, ln_gfx)) & gfx_cfg_pkg::GFX_CTRL_WRITE_MASK))
    else $error("graphics control write lost");

  a_hub_write_lands: assert property (
    wr_f0 && hit_hub && cfg_req.be[3:2] == 2'b11
    |=> hub_cfg_store == ($past(cfg_req.wdata[31:16]) & gfx_cfg_pkg::HUB_CFG_WRITE_MASK))
    else $error("hub configuration write lost");

  a_ctrl_write_lands: assert property (
    wr_f0 && hit_err && cfg_req.be[3:2] == 2'b11
    |=> error_reporting_control == ($past(cfg_req.wdata[31:16]) & gfx_cfg_pkg::ERR_LIVE_MASK))
    else $error("error reporting control write lost");

  a_err_clear_lands: assert property (
    wr_f0 && hit_err && cfg_req.be[1:0] == 2'b11 && error_events == 16'h0000
    |=> (error_flags & $past(cfg_req.wdata[15:0])) == 16'h0000)
    else $error("error flag not cleared by a one");

  // Reserved low bits of both error registers never set
  a_err_low_rsvd: assert property (
    (error_flags & ~gfx_cfg_pkg::ERR_LIVE_MASK) == 16'h0000
    && (error_reporting_control & ~gfx_cfg_pkg::ERR_LIVE_MASK) == 16'h0000)
    else $error("reserved error bits set");

  // Display limits seen from the grant and refusal sides
  a_sync_granted: assert property (
    disp_req.want_sync && !disp_req.tv0 && !disp_req.tv1
    && !(disp_req.digital0 && disp_req.digital1) |=> disp_rsp.sync_grant)
    else $error("allowed synchronous display not granted");

  a_sync_tv_refused: assert property (
    disp_req.want_sync && (disp_req.tv0 || disp_req.tv1) |=> disp_rsp.refused)
    else $error("synchronous display with a television not refused");

  a_sync_dig_refused: assert property (
    disp_req.want_sync && disp_req.digital0 && disp_req.digital1 |=> disp_rsp.refused)
    else $error("synchronous display on two digital ports not refused");

  a_no_stray_grant: assert property (
    !disp_req.want_sync |=> !disp_rsp.sync_grant)
    else $error("display grant without a synchronous request");

  // Capability low word is fixed, end-of-list pointer included
  a_cap_low_word: assert property (
    rd_f0_now && hit_cap |=> cfg_rsp.rdata == gfx_cfg_pkg::CAP_IDENT_VALUE[31:0])
    else $error("capability identification low word wrong");

endmodule

// >>> verification/graphics_mode_config_regs_bench.sv
// Self-checking bench for the graphics mode configuration registers
`timescale 1ns/1ns
module graphics_mode_config_regs_bench;
  localparam logic [2:0] CL = 3'b110;
  localparam logic [2:0] FW = 3'b101;
  logic                   core_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   hub_reset_input_n = 1'b0;
  logic                   display_card_detect = 1'b1;
  logic [15:0]            error_events = 16'h0000;
  gfx_cfg_pkg::cfg_req_t  cfg_req = '0;
  gfx_cfg_pkg::disp_req_t disp_req = '0;
  gfx_cfg_pkg::cfg_rsp_t  cfg_rsp;
  gfx_cfg_pkg::disp_rsp_t disp_rsp;
  logic                   hub_configuration_mode_bit;
  int                     failures = 0;
  int                     cmp_count = 0;
  logic [7:0]             res_off [8] = '{8'h10, 8'hA0, 8'hA4, 8'hA8, 8'hB0, 8'hB4, 8'hB8, 8'hBC};
  logic [5:0]             disp_in [6] = '{6'h20, 6'h28, 6'h24, 6'h23, 6'h22, 6'h30};
  logic [1:0]             disp_exp [6] = '{2'h2, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3};

  graphics_mode_config_regs dut_u (
    .core_clk                   (core_clk),
    .rst                        (rst),
    .hub_reset_input_n          (hub_reset_input_n),
    .display_card_detect        (display_card_detect),
    .error_events               (error_events),
    .cfg_req                    (cfg_req),
    .disp_req                   (disp_req),
    .cfg_rsp                    (cfg_rsp),
    .disp_rsp                   (disp_rsp),
    .hub_configuration_mode_bit (hub_configuration_mode_bit)
  );

  always #10 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One request, answer sampled in its single done cycle
  task automatic cfg(input logic [2:0] f, input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] wd, input logic [2:0] flags,
                     input logic [31:0] exp);
    @(negedge core_clk);
    cfg_req = '{valid: 1'b1, write: w, func: f, addr: a, be: be, wdata: wd};
    @(negedge core_clk);
    cfg_req = '0;
    chk({29'h0, cfg_rsp.done, cfg_rsp.claimed, cfg_rsp.forward}, {29'h0, flags});
    if (!w) begin
      chk(cfg_rsp.rdata, exp);
    end
  endtask

  task automatic rd(input logic [2:0] f, input logic [7:0] a, input logic [2:0] flags,
                    input logic [31:0] exp);
    cfg(f, 1'b0, a, 4'hF, 32'h0, flags, exp);
  endtask

  task automatic wr(input logic [2:0] f, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] wd, input logic [2:0] flags);
    cfg(f, 1'b1, a, be, wd, flags, 32'h0);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run is far shorter; a hang lands here
  initial begin
    #1000000;
    failures++;
    complete_run();
  end

  initial begin
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    hub_reset_input_n = 1'b1;
    @(negedge core_clk);
    display_card_detect = 1'b0;
    @(negedge core_clk);
    chk({31'h0, hub_configuration_mode_bit}, 32'h1);
    rd(3'h0, 8'hC4, CL, 32'h0008_0000);
    rd(3'h0, 8'h50, CL, 32'h0);
    rd(3'h0, 8'hC8, CL, 32'h0);
    rd(3'h1, 8'h00, CL, 32'h0);
    wr(3'h1, 8'h04, 4'hF, 32'hFFFF_FFFF, CL);
    rd(3'h1, 8'h04, CL, 32'h0);
    rd(3'h2, 8'h00, 3'b100, 32'h0);
    rd(3'h0, 8'hE4, CL, 32'h0106_0009);
    wr(3'h0, 8'hE4, 4'hF, 32'h0, CL);
    wr(3'h0, 8'hE8, 4'hF, 32'hFFFF_FFFF, CL);
    rd(3'h0, 8'hE4, CL, 32'h0106_0009);
    rd(3'h0, 8'hE8, CL, 32'h0);
    $display("test strap and capability done");

    wr(3'h0, 8'h50, 4'h4, 32'h00FF_0000, CL);
    rd(3'h0, 8'h50, CL, 32'h00F7_0000);
    wr(3'h0, 8'hC4, 4'hC, 32'hFFF7_0000, CL);
    rd(3'h0, 8'hC4, CL, 32'hFFFF_0000);
    for (int i = 0; i < 8; i++) begin
      wr(3'h0, res_off[i], 4'hF, 32'hFFFF_FFFF, CL);
      rd(3'h0, res_off[i], CL, 32'h0);
    end
    wr(3'h0, 8'h50, 4'h2, 32'h0000_FF00, CL);
    rd(3'h0, 8'h50, CL, 32'h00F7_0000);
    @(negedge core_clk);
    error_events = 16'hFFFF;
    @(negedge core_clk);
    error_events = 16'h0000;
    rd(3'h0, 8'hC8, CL, 32'h0000_FFE0);
    wr(3'h0, 8'hC8, 4'hC, 32'hFFFF_FFFF, CL);
    wr(3'h0, 8'hC8, 4'h3, 32'h0000_FFFF, CL);
    rd(3'h0, 8'hC8, CL, 32'hFFE0_0000);
    $display("test registers and reserved done");

    // Strap follows while hub reset is low, then holds
    @(negedge core_clk);
    hub_reset_input_n = 1'b0;
    display_card_detect = 1'b1;
    @(negedge core_clk);
    chk({31'h0, hub_configuration_mode_bit}, 32'h1);
    display_card_detect = 1'b0;
    @(negedge core_clk);
    hub_reset_input_n = 1'b1;
    @(negedge core_clk);
    display_card_detect = 1'b1;
    @(negedge core_clk);
    chk({31'h0, hub_configuration_mode_bit}, 32'h0);
    rd(3'h1, 8'h00, FW, 32'h0);
    wr(3'h1, 8'h04, 4'hF, 32'hFFFF_FFFF, FW);
    rd(3'h0, 8'hC4, CL, 32'hFFF7_0000);
    $display("test video output mode done");

    for (int i = 0; i < 6; i++) begin
      @(negedge core_clk);
      disp_req = disp_in[i];
      @(negedge core_clk);
      @(negedge core_clk);
      chk({30'h0, disp_rsp}, {30'h0, disp_exp[i]});
    end
    $display("test display limits done");
    complete_run();
  end
endmodule
